// *** sim/misc_cfg_regs_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module misc_cfg_regs_props
	import misc_cfg_pkg::*;
#(
	parameter bit SMALL_VARIANT = 1'b0
) (
	// Clock and reset.
	input wire logic        sys_clk,
	input wire logic        nrst,
	// Register bus.
	input wire logic [16:0] address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	// Control outputs.
	input wire logic        prescalerRun,
	input wire logic        prescalerDebugRun,
	input wire logic [2:0]  flashReadCycles,
	input wire logic [2:0]  flashReadCycleCount,
	input wire logic        flashCodeReserved,
	input wire logic        slowOscDebugRun,
	input wire logic [2:0]  ramSizeSelect,
	input wire logic        debugBaseSelect,
	input wire logic [23:0] debugBaseAddr,
	input wire logic        writeUnlocked
);
	logic [14:0] idx;
	logic        wrDone;
	assign idx = address[16:2];
	assign wrDone = write && !waitrequest && byteenable[0];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	AST_PRESC_RUN: assert property (wrDone && idx == IDX_PRESCALER |=> prescalerRun == $past(writedata[0]))
		else $error("prescaler run bit not loaded");
	AST_PRESC_DBG: assert property (wrDone && idx == IDX_PRESCALER |=> prescalerDebugRun == $past(writedata[1]))
		else $error("prescaler debug bit not loaded");
	AST_SLOW_OSC: assert property (wrDone && idx == IDX_SLOW_OSC |=> slowOscDebugRun == $past(writedata[0]))
		else $error("slow oscillator debug bit not loaded");
	// Decoded outputs must track the stored code in every cycle.
	AST_FLASH_CNT: assert property (flashReadCycleCount == (flashReadCycles > 3'h4 ? 3'h5 :
		(flashReadCycles == 3'h4 ? 3'h1 : flashReadCycles + 3'h2))) else $error("flash cycle count wrong");
	AST_FLASH_RSV: assert property (flashCodeReserved == (flashReadCycles > 3'h4))
		else $error("flash reserved flag wrong");
	AST_KEY: assert property (write && !waitrequest && byteenable[1:0] == 2'h3 && idx == IDX_PROTECT
		|=> writeUnlocked == ($past(writedata[15:0]) == UNLOCK_KEY)) else $error("unlock state wrong after key write");
	AST_LOCKED: assert property (wrDone && idx == IDX_RAM_SIZE && !writeUnlocked
		|=> $stable(ramSizeSelect) && $stable(debugBaseSelect)) else $error("locked register changed");
	AST_DBG_BASE: assert property (debugBaseAddr == (debugBaseSelect ? 24'h000000 : 24'hFFFC00))
		else $error("debug base address wrong");
	AST_RAM_READ: assert property (read && !waitrequest && idx == IDX_RAM_SIZE |-> readdata[15:0] == {7'h00,
		debugBaseSelect, 1'b0, (SMALL_VARIANT ? 3'h2 : 3'h1), 1'b0, ramSizeSelect}) else $error("ram size readback wrong");
endmodule // misc_cfg_regs_props
bind misc_system_config_regs misc_cfg_regs_props #(.SMALL_VARIANT(SMALL_VARIANT)) u_props (.sys_clk, .nrst, .address,
	.read, .write, .byteenable, .writedata, .readdata, .waitrequest, .prescalerRun, .prescalerDebugRun, .flashReadCycles,
	.flashReadCycleCount, .flashCodeReserved, .slowOscDebugRun, .ramSizeSelect, .debugBaseSelect, .debugBaseAddr,
	.writeUnlocked);
`default_nettype wire

// *** sim/misc_system_config_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module misc_system_config_regs_tb_top;
	import misc_cfg_pkg::*;
	logic        sys_clk, nrst, read, write, waitrequest, prescalerRun, prescalerDebugRun;
	logic        flashCodeReserved, slowOscDebugRun, debugBaseSelect, writeUnlocked;
	logic [2:0]  flashReadCycles, flashReadCycleCount, ramSizeSelect, ram2;
	logic [3:0]  byteenable;
	logic [16:0] address;
	logic [23:0] debugBaseAddr;
	logic [31:0] writedata, readdata, rd2, got;
	int          badCount, numChecks, cyc;
	misc_system_config_regs dut (.sys_clk, .nrst, .address, .read, .write, .byteenable, .writedata, .readdata,
		.waitrequest, .prescalerRun, .prescalerDebugRun, .flashReadCycles, .flashReadCycleCount,
		.flashCodeReserved, .slowOscDebugRun, .ramSizeSelect, .debugBaseSelect, .debugBaseAddr, .writeUnlocked);
	// The small variant rides on the same bus traffic; only its readback and size field are watched.
	misc_system_config_regs #(.SMALL_VARIANT(1'b1)) dutSmall (.sys_clk, .nrst, .address, .read, .write, .byteenable,
		.writedata, .readdata(rd2), .waitrequest(), .prescalerRun(), .prescalerDebugRun(), .flashReadCycles(),
		.flashReadCycleCount(), .flashCodeReserved(), .slowOscDebugRun(), .ramSizeSelect(ram2), .debugBaseSelect(),
		.debugBaseAddr(), .writeUnlocked());
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic tallyAndFinish();
		$display("checks %0d, mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			badCount++;
			tallyAndFinish();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		numChecks++;
		if (seen !== want) begin
			badCount++;
			$display("[ERR] %0t ns: saw %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic acc(input logic w, input logic [14:0] i, input logic [15:0] d);
		address <= {i, 2'h0};
		read <= !w;
		write <= w;
		writedata <= {16'h0000, d};
		@(posedge sys_clk);
		while (waitrequest !== 1'b0) @(posedge sys_clk);
		got = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [14:0] i, input logic [31:0] want);
		acc(1'b0, i, 16'h0000);
		chk(got, want);
	endtask
	initial begin
		nrst = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 17'h00000;
		byteenable = 4'hF;
		writedata = 32'h00000000;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		rd(IDX_PRESCALER, 32'h0);
		rd(IDX_FLASH, 32'h303);
		chk(flashReadCycleCount, 3'h5);
		rd(IDX_SLOW_OSC, 32'h0);
		rd(IDX_PROTECT, 32'h0);
		chk(writeUnlocked, 1'b0);
		rd(IDX_RAM_SIZE, 32'h11);
		chk(rd2, 32'h22);
		chk(ram2, 3'h2);
		chk(debugBaseAddr, 24'hFFFC00);
		$display("test reset values done");
		acc(1'b1, IDX_PRESCALER, 16'h00FF);
		chk({prescalerDebugRun, prescalerRun}, 2'h3);
		rd(IDX_PRESCALER, 32'h3);
		acc(1'b1, IDX_PRESCALER, 16'hFFFE);
		rd(IDX_PRESCALER, 32'h2);
		acc(1'b1, IDX_SLOW_OSC, 16'hFFFF);
		chk(slowOscDebugRun, 1'b1);
		rd(IDX_SLOW_OSC, 32'h1);
		$display("test control bits done");
		for (int c = 0; c < 8; c++) begin
			acc(1'b1, IDX_FLASH, 16'hFFF8 | 16'(c));
			chk(flashReadCycles, c);
			chk(flashReadCycleCount, c > 4 ? 3'h5 : (c == 4 ? 3'h1 : 3'(c + 2)));
			chk(flashCodeReserved, c > 4);
			rd(IDX_FLASH, 32'h300 | 32'(c));
		end
		$display("test flash timing done");
		acc(1'b1, IDX_RAM_SIZE, 16'h0103);
		rd(IDX_RAM_SIZE, 32'h11);
		acc(1'b1, IDX_PROTECT, 16'h0096);
		chk(writeUnlocked, 1'b1);
		acc(1'b1, IDX_RAM_SIZE, 16'h0103);
		rd(IDX_RAM_SIZE, 32'h113);
		chk(ramSizeSelect, 3'h3);
		chk(debugBaseSelect, 1'b1);
		chk(debugBaseAddr, 24'h000000);
		chk(rd2, 32'h123);
		acc(1'b1, IDX_RAM_SIZE, 16'hFEF6);
		rd(IDX_RAM_SIZE, 32'h16);
		chk(debugBaseAddr, 24'hFFFC00);
		acc(1'b1, IDX_PROTECT, 16'h0196);
		chk(writeUnlocked, 1'b0);
		acc(1'b1, IDX_RAM_SIZE, 16'h0101);
		rd(IDX_RAM_SIZE, 32'h16);
		$display("test write protect done");
		// Lane one alone: the key's high byte clears to give the unlock value.
		byteenable <= 4'h2;
		acc(1'b1, IDX_PROTECT, 16'h0000);
		chk(writeUnlocked, 1'b1);
		acc(1'b1, IDX_RAM_SIZE, 16'h01FF);
		chk(ramSizeSelect, 3'h6);
		chk(debugBaseSelect, 1'b1);
		acc(1'b1, IDX_PRESCALER, 16'hFFFF);
		byteenable <= 4'hF;
		rd(IDX_PRESCALER, 32'h2);
		$display("test byte lanes done");
		acc(1'b1, 15'h5328, 16'hFFFF);
		rd(15'h5328, 32'h0);
		$display("test unmapped done");
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		chk(writeUnlocked, 1'b0);
		chk(ramSizeSelect, 3'h1);
		chk(ram2, 3'h2);
		chk(debugBaseSelect, 1'b0);
		rd(IDX_FLASH, 32'h303);
		rd(IDX_PRESCALER, 32'h0);
		$display("test second reset done");
		tallyAndFinish();
	end
endmodule // misc_system_config_regs_tb_top
`default_nettype wire

// *** verilog/misc_cfg_pkg.sv ***
`default_nettype none
package misc_cfg_pkg;

	// Bus geometry: every register takes one 32-bit word at four times its index.
	localparam int          ADDR_W        = 17;
	localparam int          DATA_W        = 32;
	localparam int          IDX_W         = 15;

	// Register word indices.
	localparam logic [14:0] IDX_PRESCALER = 15'h4020;
	localparam logic [14:0] IDX_FLASH     = 15'h5320;
	localparam logic [14:0] IDX_SLOW_OSC  = 15'h5322;
	localparam logic [14:0] IDX_PROTECT   = 15'h5324;
	localparam logic [14:0] IDX_RAM_SIZE  = 15'h5326;

	// Field positions.
	localparam int          PRESC_RUN_BIT   = 0;
	localparam int          PRESC_DBG_BIT   = 1;
	localparam int          SLOW_OSC_BIT    = 0;
	localparam int          DEBUG_SEL_BIT   = 8;
	localparam int          FLASH_RSV_LSB   = 8;
	localparam int          RAM_RSV_LSB     = 4;

	// Values after reset and fixed read values.
	localparam logic        PRESC_RESET     = 1'b0;
	localparam logic        SLOW_OSC_RESET  = 1'b0;
	localparam logic        DEBUG_SEL_RESET = 1'b0;
	localparam logic [2:0]  FLASH_CYC_RESET = 3'h3;
	localparam logic [1:0]  FLASH_RSV_VALUE = 2'h3;
	localparam logic [15:0] PROTECT_RESET   = 16'h0000;
	localparam logic [15:0] UNLOCK_KEY      = 16'h0096;
	localparam logic [2:0]  RAM_RESET_LARGE = 3'h1;
	localparam logic [2:0]  RAM_RESET_SMALL = 3'h2;
	localparam logic [2:0]  RAM_RSV_LARGE   = 3'h1;
	localparam logic [2:0]  RAM_RSV_SMALL   = 3'h2;

	// Debug base addresses chosen by the select bit.
	localparam logic [23:0] DEBUG_BASE_SET  = 24'h000000;
	localparam logic [23:0] DEBUG_BASE_CLR  = 24'hFFFC00;

	// Flash read access codes and the cycle counts they give.
	localparam logic [2:0]  FLASH_CODE_2CYC = 3'h0;
	localparam logic [2:0]  FLASH_CODE_3CYC = 3'h1;
	localparam logic [2:0]  FLASH_CODE_4CYC = 3'h2;
	localparam logic [2:0]  FLASH_CODE_5CYC = 3'h3;
	localparam logic [2:0]  FLASH_CODE_1CYC = 3'h4;

	// Read access lengths in cycles; the reset code gives the five-cycle length.
	localparam logic [2:0]  FLASH_CNT_1CYC  = 3'h1;
	localparam logic [2:0]  FLASH_CNT_2CYC  = 3'h2;
	localparam logic [2:0]  FLASH_CNT_3CYC  = 3'h3;
	localparam logic [2:0]  FLASH_CNT_4CYC  = 3'h4;
	localparam logic [2:0]  FLASH_CNT_5CYC  = 3'h5;

	typedef struct packed {
		logic [15:0] key;
	} protect_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic        prescRun;
		logic        prescDbgRun;
		logic [2:0]  flashCycles;
		logic [2:0]  flashCount;
		logic        flashReserved;
		logic        slowOscDbgRun;
		logic        debugSel;
		logic [23:0] debugBase;
		logic [2:0]  ramSize;
	} cfg_s;

endpackage
`default_nettype wire

// *** verilog/misc_protect_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface misc_protect_if;
	logic        keyWrite;
	logic [15:0] keyWdata;
	logic [15:0] keyValue;
	logic        unlocked;

	modport bank (output keyWrite, output keyWdata, input keyValue, input unlocked);
	modport unit (input keyWrite, input keyWdata, output keyValue, output unlocked);
endinterface
`default_nettype wire

// *** verilog/misc_protect_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module misc_protect_unit (
	// Clock and reset.
	input  wire logic      sys_clk,
	input  wire logic      nrst,
	// Link to the register bank.
	misc_protect_if.unit   keyLink
);
	import misc_cfg_pkg::*;

	protect_s q;
	protect_s d;

	always_comb begin
		d = q;
		if (keyLink.keyWrite) begin
			d.key = keyLink.keyWdata;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			q.key <= PROTECT_RESET;
		end else begin
			q <= d;
		end
	end

	// Any key other than the unlock value restores protection.
	assign keyLink.keyValue = q.key;
	assign keyLink.unlocked = (q.key == UNLOCK_KEY);
endmodule // misc_protect_unit
`default_nettype wire

// *** verilog/misc_system_config_regs.sv ***
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module misc_system_config_regs #(
	// Set to build the smallest variant of the RAM size register.
	parameter bit SMALL_VARIANT = 1'b0
) (
	// Clock and reset.
	input  wire logic                             sys_clk,
	input  wire logic                             nrst,
	// Avalon-MM slave.
	input  wire logic [misc_cfg_pkg::ADDR_W-1:0]  address,
	input  wire logic                             read,
	input  wire logic                             write,
	input  wire logic [3:0]                       byteenable,
	input  wire logic [misc_cfg_pkg::DATA_W-1:0]  writedata,
	output logic      [misc_cfg_pkg::DATA_W-1:0]  readdata,
	output logic                                  waitrequest,
	// Prescaler controls.
	output logic                                  prescalerRun,
	output logic                                  prescalerDebugRun,
	// Flash read timing.
	output logic      [2:0]                       flashReadCycles,
	output logic      [2:0]                       flashReadCycleCount,
	output logic                                  flashCodeReserved,
	// Slow oscillator peripherals.
	output logic                                  slowOscDebugRun,
	// Internal RAM size and debug base.
	output logic      [2:0]                       ramSizeSelect,
	output logic                                  debugBaseSelect,
	output logic      [23:0]                      debugBaseAddr,
	output logic                                  writeUnlocked
);
	import misc_cfg_pkg::*;

	// The variants differ only in the RAM size reset code and the fixed bits 6:4.
	localparam logic [2:0] RAM_RESET = SMALL_VARIANT ? RAM_RESET_SMALL : RAM_RESET_LARGE;
	localparam logic [2:0] RAM_RSV   = SMALL_VARIANT ? RAM_RSV_SMALL : RAM_RSV_LARGE;

	cfg_s           q;
	cfg_s           d;
	misc_protect_if keyLink ();

	logic [IDX_W-1:0] index;
	logic             request;
	logic             accept;
	logic             doWrite;
	logic [15:0]      regWord;
	logic [31:0]      readMux;

	// The key sits in its own unit so further guarded registers can share one lock.
	misc_protect_unit u_protect (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.keyLink (keyLink)
	);

	// Merges the low two byte lanes of a write into a 16-bit register image.
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// Cycle count that each flash code gives; reserved codes report the slowest setting.
	function automatic logic [2:0] flashCount(input logic [2:0] code);
		logic [2:0] n;
		n = FLASH_CNT_5CYC;
		unique case (code)
			FLASH_CODE_2CYC: n = FLASH_CNT_2CYC;
			FLASH_CODE_3CYC: n = FLASH_CNT_3CYC;
			FLASH_CODE_4CYC: n = FLASH_CNT_4CYC;
			FLASH_CODE_5CYC: n = FLASH_CNT_5CYC;
			FLASH_CODE_1CYC: n = FLASH_CNT_1CYC;
			default:         n = FLASH_CNT_5CYC;
		endcase
		return n;
	endfunction

	// Address bits 1:0 are ignored; every register is word aligned.
	assign index   = address[ADDR_W-1:2];
	assign request = read | write;
	// One wait cycle on every access keeps read data registered.
	assign accept  = request & q.ack;
	assign doWrite = accept & write;
	assign waitrequest = request & ~q.ack;

	// Current image of the 16-bit register that the address selects.
	always_comb begin
		regWord = 16'h0000;
		unique case (index)
			IDX_PRESCALER: begin
				regWord[PRESC_RUN_BIT] = q.prescRun;
				regWord[PRESC_DBG_BIT] = q.prescDbgRun;
			end
			IDX_FLASH: begin
				regWord[2:0]                         = q.flashCycles;
				// Bits 9:8 hold no storage and always read back as ones.
				regWord[FLASH_RSV_LSB+1:FLASH_RSV_LSB] = FLASH_RSV_VALUE;
			end
			IDX_SLOW_OSC: begin
				regWord[SLOW_OSC_BIT] = q.slowOscDbgRun;
			end
			IDX_PROTECT: begin
				regWord = keyLink.keyValue;
			end
			IDX_RAM_SIZE: begin
				regWord[2:0]                       = q.ramSize;
				regWord[RAM_RSV_LSB+2:RAM_RSV_LSB] = RAM_RSV;
				regWord[DEBUG_SEL_BIT]             = q.debugSel;
			end
			default: begin
				// The vector table words above the RAM size register are not built here.
				regWord = 16'h0000;
			end
		endcase
		readMux = {16'h0000, regWord};
	end

	always_comb begin
		d = q;
		d.ack = request & ~q.ack;
		keyLink.keyWrite = 1'b0;
		keyLink.keyWdata = merge16(keyLink.keyValue, writedata, byteenable);

		// Read data is caught one cycle early so it stands when waitrequest falls.
		if (read && !q.ack) begin
			d.rdata = readMux;
		end

		// Control bits sit in lane zero; lane one carries the debug base select and the key's high byte.
		if (doWrite) begin
			unique case (index)
				IDX_PRESCALER: begin
					if (byteenable[0]) begin
						d.prescRun    = writedata[PRESC_RUN_BIT];
						d.prescDbgRun = writedata[PRESC_DBG_BIT];
					end
				end
				IDX_FLASH: begin
					if (byteenable[0]) begin
						d.flashCycles = writedata[2:0];
					end
				end
				IDX_SLOW_OSC: begin
					if (byteenable[0]) begin
						d.slowOscDbgRun = writedata[SLOW_OSC_BIT];
					end
				end
				IDX_PROTECT: begin
					keyLink.keyWrite = 1'b1;
				end
				IDX_RAM_SIZE: begin
					// A locked bank drops the write without any sign on the bus.
					if (keyLink.unlocked) begin
						// Reserved size codes are kept as written; software owns their meaning.
						if (byteenable[0]) begin
							d.ramSize = writedata[2:0];
						end
						if (byteenable[1]) begin
							d.debugSel = writedata[DEBUG_SEL_BIT];
						end
					end
				end
				default: begin
					d = d;
				end
			endcase
		end

		// Decoded outputs follow the stored code in the same cycle, so they never lag it.
		d.flashCount    = flashCount(d.flashCycles);
		d.flashReserved = (d.flashCycles > FLASH_CODE_1CYC);
		d.debugBase     = d.debugSel ? DEBUG_BASE_SET : DEBUG_BASE_CLR;
	end

	// The key clears with the rest, so the bank always comes out of reset locked.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			q.ack           <= 1'b0;
			q.rdata         <= 32'h0000_0000;
			q.prescRun      <= PRESC_RESET;
			q.prescDbgRun   <= PRESC_RESET;
			q.flashCycles   <= FLASH_CYC_RESET;
			q.flashCount    <= FLASH_CNT_5CYC;
			q.flashReserved <= 1'b0;
			q.slowOscDbgRun <= SLOW_OSC_RESET;
			q.debugSel      <= DEBUG_SEL_RESET;
			q.debugBase     <= DEBUG_BASE_CLR;
			q.ramSize       <= RAM_RESET;
		end else begin
			q <= d;
		end
	end

	assign readdata            = q.rdata;
	assign prescalerRun        = q.prescRun;
	assign prescalerDebugRun   = q.prescDbgRun;
	assign flashReadCycles     = q.flashCycles;
	assign flashReadCycleCount = q.flashCount;
	assign flashCodeReserved   = q.flashReserved;
	assign slowOscDebugRun     = q.slowOscDbgRun;
	assign ramSizeSelect       = q.ramSize;
	assign debugBaseSelect     = q.debugSel;
	assign debugBaseAddr       = q.debugBase;
	// The unlock flag is a compare on the key flop, so it moves the cycle after a key lands.
	assign writeUnlocked       = keyLink.unlocked;
endmodule // misc_system_config_regs
`default_nettype wire
